/* src/ulpi_ifc_pkg.sv */
// constants and types of the interface control register bank
package ulpi_ifc_pkg;
    localparam logic [5:0] ADDR_WRITE = 6'h07;
    localparam logic [5:0] ADDR_SET = 6'h08;
    localparam logic [5:0] ADDR_CLEAR = 6'h09;
    localparam int BIT_PROTECT_DISABLE = 7;
    localparam int BIT_PASSTHROUGH = 6;
    localparam int BIT_FAULT_INVERT = 5;
    localparam int BIT_KEEPALIVE = 3;
    localparam int BIT_THREE_WIRE = 1;
    localparam int BIT_SIX_WIRE = 0;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // reserved bits 4 and 2 hold no flip-flop and read as zero
    localparam logic [7:0] IMPL_MASK = 8'hEB;
    // link clock edges with stp high before the link counts as released
    localparam logic [3:0] PROTECT_EDGES = 4'h3;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    typedef enum logic [1:0] {
        WATCH = 2'b01,
        RELEASED = 2'b10
    } protect_state_t;
endpackage : ulpi_ifc_pkg

/* src/protect_if.sv */
// signals between the register bank and the bus protect unit
`timescale 1ns/1ps
interface protect_if;
    logic link_edge;
    logic stp;
    logic protect_disable;
    logic released;
    logic stp_pullup_en;
    logic data_pulldown_en;
    modport ctrl (
        output link_edge,
        output stp,
        output protect_disable,
        input released,
        input stp_pullup_en,
        input data_pulldown_en
    );
    modport prot (
        input link_edge,
        input stp,
        input protect_disable,
        output released,
        output stp_pullup_en,
        output data_pulldown_en
    );
endinterface : protect_if

/* src/bus_protect.sv */
// bus protect unit: watches stp at link clock edges, steers weak pulls
`timescale 1ns/1ps
module bus_protect #(
    parameter logic [3:0] EDGES = ulpi_ifc_pkg::PROTECT_EDGES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    protect_if.prot pif
);
    ulpi_ifc_pkg::protect_state_t state;
    ulpi_ifc_pkg::protect_state_t next_state;
    logic [3:0] count;
    logic [3:0] next_count;

    // a driven stp is a short pulse; a floating one stays high on the pull-up
    always_comb
    begin
        next_state = state;
        next_count = count;
        if (pif.protect_disable)
        begin
            next_state = ulpi_ifc_pkg::WATCH;
            next_count = ulpi_ifc_pkg::COUNT_ZERO;
        end
        else if (pif.link_edge)
        begin
            unique case (state)
                ulpi_ifc_pkg::WATCH:
                begin
                    if (!pif.stp)
                        next_count = ulpi_ifc_pkg::COUNT_ZERO;
                    else if (count + 4'h1 >= EDGES)
                        next_state = ulpi_ifc_pkg::RELEASED;
                    else
                        next_count = count + 4'h1;
                end
                ulpi_ifc_pkg::RELEASED:
                begin
                    if (!pif.stp)
                    begin
                        next_state = ulpi_ifc_pkg::WATCH;
                        next_count = ulpi_ifc_pkg::COUNT_ZERO;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state <= ulpi_ifc_pkg::WATCH;
            count <= ulpi_ifc_pkg::COUNT_ZERO;
        end
        else if (ce_in)
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign pif.released = (state == ulpi_ifc_pkg::RELEASED);
    assign pif.stp_pullup_en = !pif.protect_disable;
    assign pif.data_pulldown_en = pif.released && !pif.protect_disable;

    // the state falls back on the next enabled clock, without a link edge, once protection is switched off
    release_guard_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ce_in && pif.protect_disable |=> !pif.released)
        else $error("released state while protection disabled");
endmodule : bus_protect

/* src/interface_control.sv */
// interface control register bank with fault path and bus protect control
//
// Summary of operation
// - protect-disable at 0 keeps protection on and weak pull-up on stp.
// - protection on and stp unexpectedly high: weak pull-downs on all data lines.
// - protection on: device itself detects link no longer driving stp.
// - protect-disable at 1 removes the stp pull-up and data pull-downs.
// - fault passes unqualified by the bus-valid comparator.
// - fault-invert 1 inverts the fault input, 0 passes it straight.
// - keepalive governs only clock power in three- and six-wire modes.
// - keepalive ignored outside serial modes or while low power is active.
// - three-wire field moves full/low-speed packets to 3-bit serial.
// - device clears the three-wire field when that mode is left.
// - six-wire field moves full/low-speed packets to 6-bit serial.
// - device clears the six-wire field when that mode is left.
// - read at 07h to 09h, write 07h, set 08h, clear 09h.
// - low power left by link asserting stp; field returns to 1.
`timescale 1ns/1ps
module interface_control (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    input wire logic link_clk_in,
    input wire logic stp_in,
    input wire logic fault_in,
    input wire logic phy_low_power_n_in,
    input wire logic three_wire_exit_in,
    input wire logic six_wire_exit_in,
    output logic [7:0] interface_control_out,
    output logic three_wire_serial_mode_out,
    output logic six_wire_serial_mode_out,
    output logic serial_clock_power_out,
    output logic fault_complement_out,
    output logic stp_pullup_en_out,
    output logic data_pulldown_en_out,
    output logic link_released_out,
    output logic low_power_wake_out
);
    // new register value for a write through one of the three aliases
    function automatic logic [7:0] apply_access(
        input logic [7:0] old,
        input logic [7:0] wdata,
        input logic [5:0] addr
    );
        logic [7:0] value;
        value = old;
        if (addr == ulpi_ifc_pkg::ADDR_WRITE)
            value = wdata;
        else if (addr == ulpi_ifc_pkg::ADDR_SET)
            value = old | wdata;
        else if (addr == ulpi_ifc_pkg::ADDR_CLEAR)
            value = old & ~wdata;
        return value & ulpi_ifc_pkg::IMPL_MASK;
    endfunction : apply_access

    logic [7:0] control;
    logic [7:0] next_control;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic link_clk_prev;
    logic stp_at_edge;

    protect_if pif ();

    // pins from outside the clock domain: link clock, stp, fault
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            link_clk_prev <= 1'b0;
        end
        else if (ce_in)
        begin
            sync1 <= {fault_in, stp_in, link_clk_in};
            sync2 <= sync1;
            link_clk_prev <= sync2[0];
        end
    end

    wire link_edge = sync2[0] && !link_clk_prev;
    wire stp_s = sync2[1];
    wire fault_s = sync2[2];

    wire addr_mapped = (reg_addr_in >= ulpi_ifc_pkg::ADDR_WRITE)
        && (reg_addr_in <= ulpi_ifc_pkg::ADDR_CLEAR);
    wire do_write = reg_write_in && addr_mapped;
    wire do_read = reg_read_in && addr_mapped;
    wire [7:0] written = do_write ?
        apply_access(control, reg_wdata_in, reg_addr_in) : control;
    // leaving a mode wins over a write in the same cycle
    wire [7:0] exit_mask = {6'h00, three_wire_exit_in, six_wire_exit_in};
    assign next_control = written & ~exit_mask;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            control <= ulpi_ifc_pkg::RESET_VALUE;
        else if (ce_in)
            control <= next_control;
    end

    wire serial_active = control[ulpi_ifc_pkg::BIT_THREE_WIRE]
        || control[ulpi_ifc_pkg::BIT_SIX_WIRE];
    // outside serial modes the clock follows low power alone
    wire clock_power = !phy_low_power_n_in ? 1'b0 :
        serial_active ? control[ulpi_ifc_pkg::BIT_KEEPALIVE] : 1'b1;
    // no bus-valid qualification: the shared pin carries fault or power only
    wire fault_path = fault_s ^ control[ulpi_ifc_pkg::BIT_FAULT_INVERT];
    wire wake = !phy_low_power_n_in && link_edge && stp_s && !stp_at_edge;

    assign pif.link_edge = link_edge;
    assign pif.stp = stp_s;
    assign pif.protect_disable = control[ulpi_ifc_pkg::BIT_PROTECT_DISABLE];

    bus_protect #(
        .EDGES(ulpi_ifc_pkg::PROTECT_EDGES)
    ) u_bus_protect (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .pif(pif)
    );

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            stp_at_edge <= 1'b0;
        else if (ce_in && link_edge)
            stp_at_edge <= stp_s;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            reg_rdata_out <= 8'h00;
        else if (ce_in && reg_read_in)
            reg_rdata_out <= do_read ? control : 8'h00;
    end

    // pull-ups start enabled: protection is the reset state
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            serial_clock_power_out <= 1'b0;
            fault_complement_out <= 1'b0;
            stp_pullup_en_out <= 1'b1;
            data_pulldown_en_out <= 1'b0;
            link_released_out <= 1'b0;
            low_power_wake_out <= 1'b0;
        end
        else if (ce_in)
        begin
            serial_clock_power_out <= clock_power;
            fault_complement_out <= fault_path;
            stp_pullup_en_out <= pif.stp_pullup_en;
            data_pulldown_en_out <= pif.data_pulldown_en;
            link_released_out <= pif.released;
            low_power_wake_out <= wake;
        end
    end

    assign interface_control_out = control;
    assign three_wire_serial_mode_out = control[ulpi_ifc_pkg::BIT_THREE_WIRE];
    assign six_wire_serial_mode_out = control[ulpi_ifc_pkg::BIT_SIX_WIRE];

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    wire no_exit = !three_wire_exit_in && !six_wire_exit_in;

    write_store_a: assert property (
        ce_in && reg_write_in && reg_addr_in == ulpi_ifc_pkg::ADDR_WRITE && no_exit
        |=> control == ($past(reg_wdata_in) & ulpi_ifc_pkg::IMPL_MASK))
        else $error("plain write not stored");
    set_alias_a: assert property (
        ce_in && reg_write_in && reg_addr_in == ulpi_ifc_pkg::ADDR_SET && no_exit
        |=> control == (($past(control) | $past(reg_wdata_in)) & ulpi_ifc_pkg::IMPL_MASK))
        else $error("set alias wrong");
    clear_alias_a: assert property (
        ce_in && reg_write_in && reg_addr_in == ulpi_ifc_pkg::ADDR_CLEAR && no_exit
        |=> control == ($past(control) & ~$past(reg_wdata_in)))
        else $error("clear alias wrong");
    three_exit_a: assert property (
        ce_in && three_wire_exit_in |=> !three_wire_serial_mode_out)
        else $error("three-wire field not cleared on exit");
    six_exit_a: assert property (
        ce_in && six_wire_exit_in |=> !six_wire_serial_mode_out)
        else $error("six-wire field not cleared on exit");
    readback_a: assert property (
        ce_in && reg_read_in && addr_mapped |=> reg_rdata_out == $past(control))
        else $error("readback mismatch");
    protect_off_a: assert property (
        ce_in && control[ulpi_ifc_pkg::BIT_PROTECT_DISABLE]
        |=> !stp_pullup_en_out && !data_pulldown_en_out)
        else $error("pulls remain with protection disabled");
    pulldown_pair_a: assert property (
        data_pulldown_en_out |-> stp_pullup_en_out && link_released_out)
        else $error("pull-downs without protection");
    fault_invert_a: assert property (
        ce_in |=> fault_complement_out
            == ($past(fault_s) ^ $past(control[ulpi_ifc_pkg::BIT_FAULT_INVERT])))
        else $error("fault complement wrong");
    keepalive_a: assert property (
        ce_in && phy_low_power_n_in && serial_active
        |=> serial_clock_power_out == $past(control[ulpi_ifc_pkg::BIT_KEEPALIVE]))
        else $error("keepalive not applied in serial mode");

    set_alias_c: cover property (
        ce_in && reg_write_in && reg_addr_in == ulpi_ifc_pkg::ADDR_SET);
    released_c: cover property ($rose(link_released_out));
    serial_exit_c: cover property (three_wire_serial_mode_out ##1 !three_wire_serial_mode_out);
    wake_c: cover property (low_power_wake_out);
endmodule : interface_control

/* verification/link_model.sv */
// behavioural link controller driving the link clock and stp
`timescale 1ns/1ps
module link_model (
    input wire logic run_in,
    input wire logic drive_in,
    input wire logic stp_level_in,
    input wire logic pullup_en_in,
    output logic link_clk_out,
    output logic stp_out
);
    initial link_clk_out = 1'b0;
    // 200 ns half period puts link edges on falling system clock edges
    always
    begin
        #200;
        link_clk_out = run_in ? ~link_clk_out : 1'b0;
    end
    // released stp floats to the weak pull-up, else to a changed level
    assign stp_out = drive_in ? stp_level_in : (pullup_en_in | ~stp_level_in);
endmodule : link_model

/* verification/testbench.sv */
// self-checking bench for the interface control register bank
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [5:0] a_in = 6'h00;
    logic [7:0] d_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic fault_in = 1'b0;
    logic lp_n = 1'b1;
    logic ex3 = 1'b0;
    logic ex6 = 1'b0;
    logic run = 1'b0;
    logic drive = 1'b1;
    logic lvl = 1'b0;
    logic wake_seen = 1'b0;
    logic ce = 1'b1;
    logic link_clk, stp, three, six, pwr, fc, pu, pd, rel, wake;
    logic [7:0] rdata, ctrl;
    int error_cnt = 0;
    int n_checks = 0;

    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) if (wake === 1'b1) wake_seen <= 1'b1;

    link_model u_link (.run_in(run), .drive_in(drive), .stp_level_in(lvl),
        .pullup_en_in(pu), .link_clk_out(link_clk), .stp_out(stp));
    interface_control u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
        .reg_addr_in(a_in), .reg_wdata_in(d_in), .reg_write_in(wr_in), .reg_read_in(rd_in),
        .reg_rdata_out(rdata), .link_clk_in(link_clk), .stp_in(stp), .fault_in(fault_in),
        .phy_low_power_n_in(lp_n), .three_wire_exit_in(ex3), .six_wire_exit_in(ex6),
        .interface_control_out(ctrl), .three_wire_serial_mode_out(three),
        .six_wire_serial_mode_out(six), .serial_clock_power_out(pwr),
        .fault_complement_out(fc), .stp_pullup_en_out(pu), .data_pulldown_en_out(pd),
        .link_released_out(rel), .low_power_wake_out(wake));

    task chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_in);
        a_in = a;
        d_in = d;
        wr_in = 1'b1;
        @(negedge clk_in);
        wr_in = 1'b0;
    endtask : wr
    task rd(input logic [5:0] a, input logic [7:0] exp, input string nm);
        @(negedge clk_in);
        a_in = a;
        rd_in = 1'b1;
        @(negedge clk_in);
        rd_in = 1'b0;
        chk(rdata, exp, nm);
    endtask : rd
    task settle;
        repeat (4) @(negedge clk_in);
    endtask : settle
    task wait_rel(input logic v);
        for (int i = 0; i < 100 && rel !== v; i++) @(negedge clk_in);
    endtask : wait_rel
    task pulse_exit(input logic six_sel);
        @(negedge clk_in);
        if (six_sel) ex6 = 1'b1; else ex3 = 1'b1;
        @(negedge clk_in);
        ex3 = 1'b0;
        ex6 = 1'b0;
    endtask : pulse_exit
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial
    begin
        #300000;
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        repeat (6) @(negedge clk_in);
        reset_n_in = 1'b1;
        chk(ctrl, 8'h00, "reset value");
        chk({7'h00, pu}, 8'h01, "stp pull-up at reset");
        wr(ulpi_ifc_pkg::ADDR_WRITE, 8'hFD);
        rd(ulpi_ifc_pkg::ADDR_WRITE, 8'hE9, "read 07");
        rd(ulpi_ifc_pkg::ADDR_SET, 8'hE9, "read 08");
        rd(ulpi_ifc_pkg::ADDR_CLEAR, 8'hE9, "read 09");
        rd(6'h0A, 8'h00, "unmapped read");
        wr(ulpi_ifc_pkg::ADDR_CLEAR, 8'hAB);
        rd(ulpi_ifc_pkg::ADDR_WRITE, 8'h40, "clear alias");
        // a write while the clock enable is low must leave the register alone
        ce = 1'b0;
        wr(ulpi_ifc_pkg::ADDR_WRITE, 8'h00);
        chk(ctrl, 8'h40, "write frozen by enable");
        ce = 1'b1;
        wr(ulpi_ifc_pkg::ADDR_SET, 8'h02);
        rd(ulpi_ifc_pkg::ADDR_WRITE, 8'h42, "set alias");
        chk({6'h00, three, six}, 8'h02, "three-wire select");
        pulse_exit(1'b0);
        chk(ctrl, 8'h40, "three-wire exit");
        wr(ulpi_ifc_pkg::ADDR_SET, 8'h01);
        settle();
        chk({6'h00, three, six}, 8'h01, "six-wire select");
        pulse_exit(1'b1);
        chk(ctrl, 8'h40, "six-wire exit");
        $display("test registers done");
        settle();
        chk({7'h00, pwr}, 8'h01, "clock power parallel");
        wr(ulpi_ifc_pkg::ADDR_WRITE, 8'h42);
        settle();
        chk({7'h00, pwr}, 8'h00, "clock off in serial");
        wr(ulpi_ifc_pkg::ADDR_SET, 8'h08);
        settle();
        chk({7'h00, pwr}, 8'h01, "clock kept alive");
        lp_n = 1'b0;
        settle();
        chk({7'h00, pwr}, 8'h00, "keepalive ignored");
        lp_n = 1'b1;
        wr(ulpi_ifc_pkg::ADDR_WRITE, 8'h40);
        fault_in = 1'b1;
        settle();
        chk({7'h00, fc}, 8'h01, "fault straight");
        wr(ulpi_ifc_pkg::ADDR_SET, 8'h20);
        settle();
        chk({7'h00, fc}, 8'h00, "fault inverted");
        wr(ulpi_ifc_pkg::ADDR_CLEAR, 8'h20);
        $display("test clock and fault done");
        lp_n = 1'b0;
        run = 1'b1;
        repeat (40) @(negedge clk_in);
        lvl = 1'b1;
        wait_rel(1'b1);
        chk({7'h00, rel}, 8'h01, "link released");
        chk({7'h00, pd}, 8'h01, "data pull-downs on");
        chk({7'h00, wake_seen}, 8'h01, "low power wake");
        lp_n = 1'b1;
        drive = 1'b0;
        repeat (40) @(negedge clk_in);
        chk({7'h00, rel}, 8'h01, "tristated stp held");
        drive = 1'b1;
        lvl = 1'b0;
        wait_rel(1'b0);
        chk({6'h00, rel, pd}, 8'h00, "link driving again");
        lvl = 1'b1;
        wait_rel(1'b1);
        chk({7'h00, rel}, 8'h01, "released again");
        wr(ulpi_ifc_pkg::ADDR_SET, 8'h80);
        settle();
        chk({6'h00, pu, pd}, 8'h00, "protection off");
        wr(ulpi_ifc_pkg::ADDR_CLEAR, 8'h80);
        settle();
        chk({7'h00, pu}, 8'h01, "protection back on");
        run = 1'b0;
        $display("test bus protect done");
        wrap_up();
    end
endmodule : testbench
